// ---- probe_pkg.sv ----
// constants, register map and state codes of the line probe sequencer
package probe_pkg;
  localparam int CLK_KHZ = 50000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_KHZ * TICK_US / 1000;
  localparam int GAP_MS = 200;
  localparam int DUR_STEP_MS = 50;
  localparam int TOTAL_MS = 10000;
  localparam logic [5:0] DUR_MIN = 6'h01;
  localparam logic [5:0] DUR_MAX = 6'h3e;
  localparam logic [5:0] PSD_MIN = 6'h03;
  localparam logic [5:0] PSD_MAX = 6'h24;
  localparam logic [2:0] POLY_RSV = 3'h6;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DUR_OFS = 8'h04;
  localparam logic [7:0] LINK_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] RATE0_OFS = 8'h10;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_CEN = 1;
  localparam int CTRL_4W = 2;
  localparam int CTRL_SIL = 3;
  localparam int CTRL_POLY = 4;
  localparam int DUR_REM = 0;
  localparam int DUR_CEN = 8;
  localparam int LINK_MREM = 0;
  localparam int LINK_MCEN = 8;
  localparam int LINK_BO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_OVR = 2;
  localparam int STAT_SKIP = 3;
  localparam int STAT_SIDE = 4;
  localparam int STAT_SLOT = 8;
  localparam int RATE_DIV = 0;
  localparam int RATE_PSD = 16;
  localparam logic [5:0] DUR_RST = 6'h01;
  localparam logic [3:0] BACKOFF_RST = 4'h6;
  localparam logic [15:0] DIV_RST = 16'h0019;
  localparam logic [5:0] PSD_RST = 6'h03;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LEAD = 4'h2,
    S_BURST = 4'h4,
    S_TAIL = 4'h8
  } phase_e;
endpackage

// ---- line_probe.sv ----
// line probe sequencer with preactivation scrambler and apb register file
`timescale 1ns/1ns
module line_probe #(
  parameter int NUM_RATES = 4,
  parameter int TICK_CYC = probe_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hs1_done,
  output logic hs2_start,
  output logic probe_abort,
  output logic tx_bit,
  output logic sym_stb,
  output logic tx_en_pair1,
  output logic tx_en_pair2,
  output logic [2:0] rate_slot,
  output logic [5:0] psd_code,
  output logic [3:0] backoff
);
  localparam int TW = $clog2(TICK_CYC + 1);
  if (NUM_RATES < 1 || NUM_RATES > 8 || TICK_CYC < 2)
    $error("line_probe: unsupported parameters");
  typedef struct packed {
    probe_pkg::phase_e st;
    logic side;
    logic [2:0] slot;
    logic [11:0] ms_cnt;
    logic [13:0] total_ms;
    logic [TW-1:0] tick_cnt;
    logic [15:0] sym_cnt;
    logic [22:0] sr;
    logic sel, cen, fw, sil;
    logic [2:0] poly;
    logic [5:0] dur_rem, dur_cen;
    logic [NUM_RATES-1:0] mask_rem, mask_cen;
    logic [3:0] bo;
    logic [NUM_RATES-1:0][15:0] div;
    logic [NUM_RATES-1:0][5:0] psd;
    logic done, overrun, skipped;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic tx_bit, tx_p1, tx_p2, sym_stb, hs2, abort_p;
    logic [5:0] psd_o;
    logic [3:0] bo_o;
  } state_s;
  state_s q_r, q_nxt;
  logic [NUM_RATES-1:0] rate_hit;
  logic [11:0] blen_chk;
  assign blen_chk = 12'((q_r.side ? q_r.dur_cen : q_r.dur_rem) * probe_pkg::DUR_STEP_MS);
  genvar g;
  generate
    for (g = 0; g < NUM_RATES; g++)
    begin : g_hit
      assign rate_hit[g] = paddr == probe_pkg::RATE0_OFS + 8'(4 * g);
    end
  endgenerate
  // lowest set mask bit at or above from; msb of result flags a hit
  function automatic logic [3:0] first_at(input logic [NUM_RATES-1:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NUM_RATES - 1; k >= 0; k--)
      if (m[k] && k >= int'(from))
        r = {1'b1, 3'(k)};
    return r;
  endfunction
  // feedback taps; h[k-1] holds the output k symbols back
  function automatic logic taps(input logic [2:0] p, input logic c, input logic [22:0] h);
    case (p)
      3'h0: taps = c ? h[4] ^ h[22] : h[17] ^ h[22];
      3'h1: taps = h[0];
      3'h2: taps = c ? h[1] ^ h[4] : h[2] ^ h[4];
      3'h3: taps = c ? h[0] ^ h[5] : h[4] ^ h[5];
      3'h4: taps = c ? h[2] ^ h[6] : h[3] ^ h[6];
      3'h5: taps = c ? h[1] ^ h[2] ^ h[3] ^ h[7] : h[3] ^ h[4] ^ h[5] ^ h[7];
      default: taps = 1'b0;
    endcase
  endfunction
  always_comb
  begin
    logic [3:0] nx;
    logic tick;
    logic newbit;
    logic mapped;
    logic wr;
    nx = 4'h0;
    q_nxt = q_r;
    tick = q_r.tick_cnt == TW'(TICK_CYC - 1);
    newbit = 1'b1 ^ taps(q_r.poly, q_r.cen, q_r.sr);
    mapped = (|rate_hit) || paddr == probe_pkg::CTRL_OFS || paddr == probe_pkg::DUR_OFS
      || paddr == probe_pkg::LINK_OFS || paddr == probe_pkg::STAT_OFS;
    wr = psel && penable && q_r.pready && pwrite && !q_r.pslverr;
    q_nxt.pready = 1'b0;
    q_nxt.sym_stb = 1'b0;
    q_nxt.hs2 = 1'b0;
    q_nxt.abort_p = 1'b0;
    // apb: answer is prepared in setup so every output leaves a flop
    if (psel && !penable)
    begin
      q_nxt.pready = 1'b1;
      q_nxt.prdata = 32'h0;
      // writes set up while busy are refused; one set up in the cycle hs1_done starts the probe is applied one cycle into it
      q_nxt.pslverr = !mapped || (pwrite && q_r.st != probe_pkg::S_IDLE);
      unique case (1'b1)
        paddr == probe_pkg::CTRL_OFS:
        begin
          q_nxt.prdata[probe_pkg::CTRL_SEL] = q_r.sel;
          q_nxt.prdata[probe_pkg::CTRL_CEN] = q_r.cen;
          q_nxt.prdata[probe_pkg::CTRL_4W] = q_r.fw;
          q_nxt.prdata[probe_pkg::CTRL_SIL] = q_r.sil;
          q_nxt.prdata[probe_pkg::CTRL_POLY +: 3] = q_r.poly;
        end
        paddr == probe_pkg::DUR_OFS:
        begin
          q_nxt.prdata[probe_pkg::DUR_REM +: 6] = q_r.dur_rem;
          q_nxt.prdata[probe_pkg::DUR_CEN +: 6] = q_r.dur_cen;
        end
        paddr == probe_pkg::LINK_OFS:
        begin
          q_nxt.prdata[probe_pkg::LINK_MREM +: NUM_RATES] = q_r.mask_rem;
          q_nxt.prdata[probe_pkg::LINK_MCEN +: NUM_RATES] = q_r.mask_cen;
          q_nxt.prdata[probe_pkg::LINK_BO +: 4] = q_r.bo;
        end
        paddr == probe_pkg::STAT_OFS:
        begin
          q_nxt.prdata[probe_pkg::STAT_BUSY] = q_r.st != probe_pkg::S_IDLE;
          q_nxt.prdata[probe_pkg::STAT_DONE] = q_r.done;
          q_nxt.prdata[probe_pkg::STAT_OVR] = q_r.overrun;
          q_nxt.prdata[probe_pkg::STAT_SKIP] = q_r.skipped;
          q_nxt.prdata[probe_pkg::STAT_SIDE] = q_r.side;
          q_nxt.prdata[probe_pkg::STAT_SLOT +: 3] = q_r.slot;
        end
        default:
          for (int k = 0; k < NUM_RATES; k++)
            if (rate_hit[k])
            begin
              q_nxt.prdata[probe_pkg::RATE_DIV +: 16] = q_r.div[k];
              q_nxt.prdata[probe_pkg::RATE_PSD +: 6] = q_r.psd[k];
            end
      endcase
    end
    // out-of-range writes to a field leave it unchanged
    if (wr)
    begin
      if (paddr == probe_pkg::CTRL_OFS)
      begin
        q_nxt.sel = pwdata[probe_pkg::CTRL_SEL];
        q_nxt.cen = pwdata[probe_pkg::CTRL_CEN];
        q_nxt.fw = pwdata[probe_pkg::CTRL_4W];
        q_nxt.sil = pwdata[probe_pkg::CTRL_SIL];
        if (pwdata[probe_pkg::CTRL_POLY +: 3] < probe_pkg::POLY_RSV)
          q_nxt.poly = pwdata[probe_pkg::CTRL_POLY +: 3];
      end
      if (paddr == probe_pkg::DUR_OFS)
      begin
        if (pwdata[probe_pkg::DUR_REM +: 6] >= probe_pkg::DUR_MIN
            && pwdata[probe_pkg::DUR_REM +: 6] <= probe_pkg::DUR_MAX)
          q_nxt.dur_rem = pwdata[probe_pkg::DUR_REM +: 6];
        if (pwdata[probe_pkg::DUR_CEN +: 6] >= probe_pkg::DUR_MIN
            && pwdata[probe_pkg::DUR_CEN +: 6] <= probe_pkg::DUR_MAX)
          q_nxt.dur_cen = pwdata[probe_pkg::DUR_CEN +: 6];
      end
      if (paddr == probe_pkg::LINK_OFS)
      begin
        q_nxt.mask_rem = pwdata[probe_pkg::LINK_MREM +: NUM_RATES];
        q_nxt.mask_cen = pwdata[probe_pkg::LINK_MCEN +: NUM_RATES];
        q_nxt.bo = pwdata[probe_pkg::LINK_BO +: 4];
      end
      for (int k = 0; k < NUM_RATES; k++)
        if (rate_hit[k])
        begin
          if (pwdata[probe_pkg::RATE_DIV +: 16] != 16'h0)
            q_nxt.div[k] = pwdata[probe_pkg::RATE_DIV +: 16];
          if (pwdata[probe_pkg::RATE_PSD +: 6] >= probe_pkg::PSD_MIN
              && pwdata[probe_pkg::RATE_PSD +: 6] <= probe_pkg::PSD_MAX)
            q_nxt.psd[k] = pwdata[probe_pkg::RATE_PSD +: 6];
        end
    end
    // millisecond timebase runs only while the sequence is busy
    if (q_r.st != probe_pkg::S_IDLE)
    begin
      q_nxt.tick_cnt = tick ? TW'(0) : q_r.tick_cnt + TW'(1);
      q_nxt.ms_cnt = q_r.ms_cnt + 12'(tick);
      q_nxt.total_ms = q_r.total_ms + 14'(tick);
    end
    unique case (q_r.st)
      probe_pkg::S_IDLE:
        if (hs1_done)
        begin
          q_nxt.done = 1'b0;
          q_nxt.overrun = 1'b0;
          q_nxt.skipped = !q_r.sel;
          if (!q_r.sel)
            q_nxt.hs2 = 1'b1;
          else
          begin
            q_nxt.sr = 23'h0;
            q_nxt.tick_cnt = TW'(0);
            q_nxt.ms_cnt = 12'h000;
            q_nxt.total_ms = 14'h0000;
            q_nxt.st = probe_pkg::S_LEAD;
            nx = first_at(q_r.mask_rem, 4'h0);
            q_nxt.side = !nx[3];
            if (!nx[3])
              nx = first_at(q_r.mask_cen, 4'h0);
            q_nxt.slot = nx[2:0];
            if (!nx[3])
              q_nxt.st = probe_pkg::S_TAIL;
          end
        end
      probe_pkg::S_LEAD:
        if (tick && q_r.ms_cnt == 12'(probe_pkg::GAP_MS - 1))
        begin
          q_nxt.st = probe_pkg::S_BURST;
          q_nxt.ms_cnt = 12'h000;
          q_nxt.sym_cnt = 16'h0;
          q_nxt.psd_o = q_r.psd[q_r.slot];
          q_nxt.bo_o = q_r.bo;
          q_nxt.tx_p1 = q_r.side == q_r.cen && !q_r.sil;
          q_nxt.tx_p2 = q_r.side == q_r.cen && !q_r.sil && q_r.fw;
        end
      probe_pkg::S_BURST:
      begin
        q_nxt.sym_cnt = q_r.sym_cnt + 16'h1;
        if (q_r.sym_cnt == q_r.div[q_r.slot] - 16'h1)
        begin
          q_nxt.sym_cnt = 16'h0;
          // no symbol on the closing edge, so every strobe lands inside the enable
          if (q_r.tx_p1 && !(tick && q_r.ms_cnt == blen_chk - 12'h001))
          begin
            q_nxt.sr = {q_r.sr[21:0], newbit};
            q_nxt.tx_bit = newbit;
            q_nxt.sym_stb = 1'b1;
          end
        end
        if (tick && q_r.ms_cnt == blen_chk - 12'h001)
        begin
          q_nxt.tx_p1 = 1'b0;
          q_nxt.tx_p2 = 1'b0;
          q_nxt.ms_cnt = 12'h000;
          q_nxt.st = probe_pkg::S_LEAD;
          nx = first_at(q_r.side ? q_r.mask_cen : q_r.mask_rem, {1'b0, q_r.slot} + 4'h1);
          if (!nx[3] && !q_r.side)
          begin
            q_nxt.side = 1'b1;
            nx = first_at(q_r.mask_cen, 4'h0);
          end
          q_nxt.slot = nx[2:0];
          if (!nx[3])
            q_nxt.st = probe_pkg::S_TAIL;
        end
      end
      probe_pkg::S_TAIL:
        if (tick && q_r.ms_cnt == 12'(probe_pkg::GAP_MS - 1))
        begin
          q_nxt.st = probe_pkg::S_IDLE;
          q_nxt.hs2 = 1'b1;
          q_nxt.done = 1'b1;
        end
      default:
        q_nxt.st = probe_pkg::S_IDLE;
    endcase
    // a phase that would run past the limit is cut short, line left silent
    if (q_r.st != probe_pkg::S_IDLE && q_nxt.st != probe_pkg::S_IDLE && tick
        && q_r.total_ms == 14'(probe_pkg::TOTAL_MS - 1))
    begin
      q_nxt.st = probe_pkg::S_IDLE;
      q_nxt.tx_p1 = 1'b0;
      q_nxt.tx_p2 = 1'b0;
      q_nxt.sym_stb = 1'b0;
      q_nxt.tx_bit = q_r.tx_bit;
      q_nxt.overrun = 1'b1;
      q_nxt.abort_p = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_r <= '0;
      q_r.st <= probe_pkg::S_IDLE;
      q_r.dur_rem <= probe_pkg::DUR_RST;
      q_r.dur_cen <= probe_pkg::DUR_RST;
      q_r.bo <= probe_pkg::BACKOFF_RST;
      q_r.div <= {NUM_RATES{probe_pkg::DIV_RST}};
      q_r.psd <= {NUM_RATES{probe_pkg::PSD_RST}};
    end
    else
      q_r <= q_nxt;
  end
  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign hs2_start = q_r.hs2;
  assign probe_abort = q_r.abort_p;
  assign tx_bit = q_r.tx_bit;
  assign sym_stb = q_r.sym_stb;
  assign tx_en_pair1 = q_r.tx_p1;
  assign tx_en_pair2 = q_r.tx_p2;
  assign rate_slot = q_r.slot;
  assign psd_code = q_r.psd_o;
  assign backoff = q_r.bo_o;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_gap_length: assert property (q_r.st == probe_pkg::S_LEAD ##1 q_r.st == probe_pkg::S_BURST
    |-> $past(q_r.ms_cnt) == 12'(probe_pkg::GAP_MS - 1))
    else $error("gap before burst has wrong length");
  a_burst_length: assert property (q_r.st == probe_pkg::S_BURST ##1 q_r.st == probe_pkg::S_LEAD
    |-> $past(q_r.ms_cnt) == $past(blen_chk) - 12'h001)
    else $error("burst has wrong length");
  a_hs2_after_tail: assert property ($rose(q_r.hs2) && q_r.sel |-> $past(q_r.st) == probe_pkg::S_TAIL)
    else $error("second handshake started without closing gap");
  a_total_limit: assert property (q_r.total_ms <= 14'(probe_pkg::TOTAL_MS))
    else $error("probe phase exceeded limit");
  a_skip_probe: assert property (q_r.st == probe_pkg::S_IDLE && hs1_done && !q_r.sel
    |=> q_r.hs2 && q_r.st == probe_pkg::S_IDLE && !q_r.tx_p1)
    else $error("probe not skipped when deselected");
  a_slot_up: assert property (q_r.st == probe_pkg::S_LEAD && $past(q_r.st) == probe_pkg::S_BURST
    && q_r.side == $past(q_r.side) |-> q_r.slot > $past(q_r.slot))
    else $error("rates not in ascending order");
  a_scr_step: assert property (q_r.sym_stb |-> q_r.sr[0] == q_r.tx_bit && q_r.tx_p1)
    else $error("symbol not taken from scrambler");
  a_silent_slot: assert property (q_r.sil && q_r.st != probe_pkg::S_IDLE |-> !q_r.tx_p1)
    else $error("silent slot drives the line");
  a_pair2: assert property (q_r.tx_p2 |-> q_r.tx_p1 && q_r.fw)
    else $error("second pair driven alone");
  a_poly_legal: assert property (q_r.poly < probe_pkg::POLY_RSV)
    else $error("illegal polynomial held");
  a_scr_clear: assert property (q_r.st == probe_pkg::S_IDLE && hs1_done && q_r.sel
    |=> q_r.sr == 23'h0 ##1 q_r.st == probe_pkg::S_LEAD || q_r.st == probe_pkg::S_TAIL)
    else $error("scrambler not cleared at start");
endmodule

// ---- peer_model.sv ----
// far-end transceiver model: reference scrambler that checks each received probe symbol
`timescale 1ns/1ns
module peer_model (
  input wire logic pclk,
  input wire logic start,
  input wire logic central,
  input wire logic [2:0] poly,
  input wire logic tx_bit,
  input wire logic sym_stb,
  input wire logic tx_en_pair1,
  output int err_cnt,
  output int sym_cnt
);
  logic [22:0] hist;
  logic exp_bit;
  // bit d-1 of the mask is the tap at delay d
  function automatic logic [22:0] taps(input logic [2:0] p, input logic c);
    case (p)
      3'h0: taps = c ? 23'h400010 : 23'h420000;
      3'h1: taps = 23'h000001;
      3'h2: taps = c ? 23'h000012 : 23'h000014;
      3'h3: taps = c ? 23'h000021 : 23'h000030;
      3'h4: taps = c ? 23'h000044 : 23'h000048;
      default: taps = c ? 23'h00008e : 23'h0000b8;
    endcase
  endfunction
  // sampled mid-cycle so design registers have settled
  always @(negedge pclk)
  begin
    if (start === 1'b1)
    begin
      hist = '0;
      err_cnt = 0;
      sym_cnt = 0;
    end
    else if (sym_stb === 1'b1)
    begin
      exp_bit = ~(^(hist & taps(poly, central)));
      if (tx_bit !== exp_bit || tx_en_pair1 !== 1'b1)
        err_cnt = err_cnt + 1;
      // history follows the reference, so one bad bit counts once
      hist = {hist[21:0], exp_bit};
      sym_cnt = sym_cnt + 1;
    end
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the line probe sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int T = 2;
  localparam int GAP = probe_pkg::GAP_MS * T;
  localparam int TOL = 10 * T;
  localparam int STEP = probe_pkg::DUR_STEP_MS * T;
  logic pclk, presetn, psel, penable, pwrite, hs1_done, pready, pslverr, hs2_start, probe_abort;
  logic tx_bit, sym_stb, tx_en_pair1, tx_en_pair2, cen_m, four_w, en_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] rate_slot, poly_m;
  logic [5:0] psd_code;
  logic [3:0] backoff;
  int mismatches, checked, cyc, t0, hs2_t, abort_t, hs2_n, abort_n, pair_bad, err_cnt, sym_cnt;
  int rise[$], fall[$];
  logic [31:0] info[$];
  line_probe #(.NUM_RATES(4), .TICK_CYC(T)) line_probe_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hs1_done(hs1_done), .hs2_start(hs2_start), .probe_abort(probe_abort), .tx_bit(tx_bit),
    .sym_stb(sym_stb), .tx_en_pair1(tx_en_pair1), .tx_en_pair2(tx_en_pair2), .rate_slot(rate_slot),
    .psd_code(psd_code), .backoff(backoff));
  peer_model peer_model_inst (.pclk(pclk), .start(hs1_done), .central(cen_m), .poly(poly_m), .tx_bit(tx_bit),
    .sym_stb(sym_stb), .tx_en_pair1(tx_en_pair1), .err_cnt(err_cnt), .sym_cnt(sym_cnt));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic conclude();
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_near(input int got, input int exp, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // monitor samples mid-cycle; times are cycles after the handshake-end pulse
  always @(negedge pclk)
  begin
    cyc++;
    if (hs1_done === 1'b1)
      t0 = cyc;
    if (tx_en_pair1 === 1'b1 && en_q === 1'b0)
    begin
      rise.push_back(cyc - t0);
      info.push_back({19'h0, rate_slot, psd_code, backoff});
    end
    if (tx_en_pair1 === 1'b0 && en_q === 1'b1)
      fall.push_back(cyc - t0);
    if (tx_en_pair2 !== (tx_en_pair1 & four_w))
      pair_bad++;
    if (hs2_start === 1'b1)
    begin
      hs2_t = cyc - t0;
      hs2_n++;
    end
    if (probe_abort === 1'b1)
    begin
      abort_t = cyc - t0;
      abort_n++;
    end
    en_q = tx_en_pair1;
    if (cyc == 60000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is sampled high; a hang ends at the bench timeout
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    cmp_val(rd, exp);
    cmp_val(er, eexp);
  endtask
  task automatic run_seq(input logic [31:0] ctrl, input logic [31:0] dur, input logic [31:0] link);
    apb_wr(probe_pkg::CTRL_OFS, ctrl);
    apb_wr(probe_pkg::DUR_OFS, dur);
    apb_wr(probe_pkg::LINK_OFS, link);
    rise.delete();
    fall.delete();
    info.delete();
    hs2_n = 0;
    abort_n = 0;
    pair_bad = 0;
    four_w = ctrl[2];
    poly_m <= ctrl[6:4];
    cen_m <= ctrl[1];
    @(posedge pclk);
    hs1_done <= 1'b1;
    @(posedge pclk);
    hs1_done <= 1'b0;
  endtask
  task automatic wait_end();
    while (hs2_n == 0 && abort_n == 0)
      @(negedge pclk);
    @(posedge pclk);
  endtask
  // nominal schedule: lead gap, remote-side then central-side bursts lowest slot first, gaps, tail gap; only own side driven
  task automatic chk_run(input logic [7:0] rm, cm, input int dr, dc, input int cen, sil, input logic [3:0] bo);
    int t, n, d;
    logic [7:0] m;
    t = GAP;
    n = 0;
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 4; k++)
      begin
        m = s ? cm : rm;
        d = (s ? dc : dr) * STEP;
        if (m[k] && s == cen && sil == 0)
        begin
          cmp_near(rise[n], t, TOL);
          cmp_near(fall[n] - rise[n], d, TOL);
          cmp_val(info[n], {19'h0, k[2:0], 6'(4 + k), bo});
          n++;
        end
        if (m[k])
          t += d + GAP;
      end
    cmp_near(rise.size(), n, 0);
    cmp_near(hs2_t, t, TOL);
    cmp_near(pair_bad, 0, 0);
  endtask
  initial
  begin
    logic [31:0] rd;
    logic er;
    {presetn, psel, penable, pwrite, hs1_done, cen_m, four_w} = '0;
    {paddr, pwdata, poly_m} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(probe_pkg::CTRL_OFS, 32'h0, 1'b0);
    chk_rd(probe_pkg::DUR_OFS, 32'h00000101, 1'b0);
    chk_rd(probe_pkg::LINK_OFS, 32'h00060000, 1'b0);
    chk_rd(probe_pkg::RATE0_OFS, 32'h00030019, 1'b0);
    chk_rd(8'hfc, 32'h0, 1'b1);
    apb_wr(probe_pkg::CTRL_OFS, 32'h50);
    for (int p = 6; p < 8; p++)
    begin
      apb_wr(probe_pkg::CTRL_OFS, 32'(p << 4));
      chk_rd(probe_pkg::CTRL_OFS, 32'h50, 1'b0);
    end
    // slot 0 runs one symbol per clock to get many symbols per short burst
    for (int k = 0; k < 4; k++)
      apb_wr(probe_pkg::RATE0_OFS + 8'(4 * k), {10'h0, 6'(4 + k), 16'(k == 0 ? 1 : 2 + k)});
    for (int v = 2; v < 40; v += 35)
    begin
      apb_wr(probe_pkg::RATE0_OFS, 32'(v << 16) | 32'h1);
      chk_rd(probe_pkg::RATE0_OFS, 32'h00040001, 1'b0);
    end
    run_seq(32'h0, 32'h0101, 32'h0);
    wait_end();
    cmp_near(hs2_t, 1, 1);
    cmp_near(rise.size(), 0, 0);
    chk_rd(probe_pkg::STAT_OFS, 32'h00000008, 1'b0);
    run_seq(32'h5, 32'h0102, 32'h00090205);
    apb(1'b1, probe_pkg::CTRL_OFS, 32'h0, rd, er);
    cmp_val(er, 1'b1);
    wait_end();
    chk_run(8'h5, 8'h2, 2, 1, 0, 0, 4'h9);
    chk_rd(probe_pkg::CTRL_OFS, 32'h5, 1'b0);
    run_seq(32'h3, 32'h0201, 32'h00000903);
    wait_end();
    chk_run(8'h3, 8'h9, 1, 2, 1, 0, 4'h0);
    run_seq(32'h9, 32'h0101, 32'h00060001);
    wait_end();
    chk_run(8'h1, 8'h0, 1, 1, 0, 1, 4'h6);
    for (int p = 0; p < 6; p++)
      for (int c = 0; c < 2; c++)
      begin
        run_seq(32'((p << 4) | (c << 1) | 1), 32'h0101, c ? 32'h00060100 : 32'h00060001);
        wait_end();
        cmp_near(err_cnt, 0, 0);
        cmp_near(sym_cnt, STEP, TOL);
        chk_run(8'(1 - c), 8'(c), 1, 1, c, 0, 4'h6);
      end
    run_seq(32'h1, 32'h3e3e, 32'h0006000f);
    wait_end();
    cmp_near(abort_n, 1, 0);
    cmp_near(hs2_n, 0, 0);
    cmp_near(abort_t, probe_pkg::TOTAL_MS * T, TOL);
    chk_rd(probe_pkg::STAT_OFS, 32'h00000304, 1'b0);
    conclude();
  end
endmodule
